// >>> dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        core_clk, arst_n, req_start, req_once_only, resp_ready, tx_ready;
  logic        req_busy, req_done, req_ok, resp_last, resp_bad, resp_valid, resp_user_valid;
  logic        tx_valid, tx_last, rx_valid, rx_last, rx_ready;
  logic        sts_once, junk, mute, slow;
  logic [7:0]  req_bitmap, resp_data, tx_data, rx_data, drop_map;
  logic [31:0] req_user, resp_user;
  logic [15:0] req_timeout_ticks, req_tag, tag_exp;
  logic [3:0]  req_max_retries, req_rcv_count, eom_seq;
  logic [2:0]  resp_seq;
  logic [63:0] last_hdr, req_hdr;
  int          n_pkt, pkt0, n_bytes, bytes0, n_mismatch, cmp_count, cyc;

  tpe_requester #(.TICK_CYCLES_P(4)) uut (
    .core_clk, .arst_n, .req_start, .req_once_only, .req_bitmap, .req_user,
    .req_timeout_ticks, .req_max_retries, .req_busy, .req_done, .req_ok, .req_rcv_count,
    .req_tag, .resp_data, .resp_seq, .resp_last, .resp_bad, .resp_valid, .resp_ready,
    .resp_user, .resp_user_valid, .tx_data, .tx_valid, .tx_last, .tx_ready,
    .rx_data, .rx_valid, .rx_last, .rx_ready);

  tpe_peer peer (
    .core_clk, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_last, .rx_ready,
    .drop_map, .eom_seq, .sts_once, .junk, .mute, .slow, .last_hdr, .req_hdr, .n_pkt);

  task automatic summarize();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic run(input logic once, input logic [7:0] bm, input logic [3:0] rt,
                     input logic [15:0] ticks);
    int n;
    @(posedge core_clk);
    #1;
    req_once_only     = once;
    req_bitmap        = bm;
    req_max_retries   = rt;
    req_timeout_ticks = ticks;
    pkt0              = n_pkt;
    bytes0            = n_bytes;
    req_start         = 1'b1;
    @(posedge core_clk);
    #1 req_start = 1'b0;
    check(req_busy, 1'b1);
    n = 0;
    while (req_done !== 1'b1 && n < 5000) begin
      @(posedge core_clk);
      #1 n++;
    end
    check(req_done, 1'b1);
    check(req_tag, tag_exp);
    tag_exp++;
    while (req_busy !== 1'b0 && n < 5000) begin
      @(posedge core_clk);
      #1 n++;
    end
    check(req_busy, 1'b0);
    repeat (3) @(posedge core_clk);
    #1;
  endtask : run

  task automatic t_basic();
    junk = 1'b1;
    run(1'b0, 8'h3f, 4'h2, 16'h003c);
    junk = 1'b0;
    check(req_ok, 1'b1);
    check(req_rcv_count, 4'h6);
    check(n_bytes - bytes0, 12);
    check(req_hdr[63:56], {tpe_pkg::FN_REQ, 6'h00});
    check(req_hdr[55:48], 8'h3f);
    check(req_hdr[47:32], tag_exp - 16'h0001);
    check(req_hdr[31:0], 32'h1357_9bdf);
  endtask : t_basic

  task automatic t_eom();
    slow    = 1'b1;
    eom_seq = 4'h2;
    run(1'b0, 8'hff, 4'h2, 16'h003c);
    slow    = 1'b0;
    eom_seq = 4'h8;
    check(req_ok, 1'b1);
    check(req_rcv_count, 4'h3);
  endtask : t_eom

  task automatic t_retry();
    drop_map = 8'h04;
    run(1'b0, 8'h0f, 4'h2, 16'h003c);
    drop_map = 8'h00;
    check(n_pkt - pkt0, 2);
    check(req_hdr[55:32], {8'h04, tag_exp - 16'h0001});
    check(req_rcv_count, 4'h4);
  endtask : t_retry

  task automatic t_fail();
    mute = 1'b1;
    run(1'b0, 8'h01, 4'h2, 16'h000a);
    mute = 1'b0;
    check(req_ok, 1'b0);
    check(n_pkt - pkt0, 3);
    check(req_rcv_count, 4'h0);
  endtask : t_fail

  task automatic t_sts();
    sts_once = 1'b1;
    run(1'b0, 8'h07, 4'h0, 16'h003c);
    sts_once = 1'b0;
    check(req_ok, 1'b1);
    check(n_pkt - pkt0, 2);
    check(req_hdr[55:48], 8'h06);
  endtask : t_sts

  task automatic t_once();
    run(1'b1, 8'h01, 4'h2, 16'h003c);
    check(req_hdr[61], 1'b1);
    check(n_pkt - pkt0, 2);
    check(last_hdr[63:62], tpe_pkg::FN_REL);
    check(last_hdr[55:32], {8'h00, tag_exp - 16'h0001});
  endtask : t_once

  always @(posedge core_clk) begin
    if (resp_valid === 1'b1 && resp_ready) begin
      n_bytes++;
      check(resp_data[3:0], {1'b0, resp_seq});
      check(resp_last, resp_data[7:4] == 4'hb);
      check(resp_bad, 1'b0);
    end
    if (resp_user_valid === 1'b1)
      check(resp_user, 32'hc0c1_c2c3);
  end

  // drain at half rate so the two-entry buffer fills and pushes back
  always @(posedge core_clk) #1 resp_ready = ~resp_ready;

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    arst_n = 1'b0;
    {req_start, req_once_only, resp_ready, sts_once, junk, mute, slow} = '0;
    {req_bitmap, drop_map, req_timeout_ticks, req_max_retries} = '0;
    req_user   = 32'h1357_9bdf;
    eom_seq    = 4'h8;
    tag_exp    = 16'h0000;
    n_bytes    = 0;
    n_mismatch = 0;
    cmp_count  = 0;
    cyc        = 0;
    repeat (4) @(posedge core_clk);
    #1 arst_n = 1'b1;
    check(req_tag, 16'hffff);
    t_basic();
    t_eom();
    t_retry();
    t_fail();
    t_sts();
    t_once();
    summarize();
  end
endmodule : tb_top

// >>> dv/tpe_peer.sv
`timescale 1ns/100ps
module tpe_peer (
  input  wire logic       core_clk,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_last,
  input  wire logic       rx_ready,
  input  wire logic [7:0] drop_map,
  input  wire logic [3:0] eom_seq,
  input  wire logic       sts_once,
  input  wire logic       junk,
  input  wire logic       mute,
  input  wire logic       slow,
  output logic [63:0]     last_hdr,
  output logic [63:0]     req_hdr,
  output int              n_pkt
);
  logic [7:0]  hdr [8];
  logic [15:0] prev_tag;
  logic        fresh;
  int          k;

  // holds byte and valid until taken; valid stays up across a packet
  task automatic put(input logic [7:0] b, input logic l);
    rx_data  = b;
    rx_valid = 1'b1;
    rx_last  = l;
    do @(posedge core_clk); while (rx_ready !== 1'b1);
    #1;
  endtask : put

  task automatic pkt(input logic [1:0] fn, input int s, input logic end_of_message_flag, input logic sts);
    put({fn, 1'b0, end_of_message_flag, sts, 3'b000}, 1'b0);
    put(8'(s), 1'b0);
    put(hdr[2], 1'b0);
    put(hdr[3], 1'b0);
    for (int u = 0; u < 4; u++) put(8'hc0 + 8'(u), 1'b0);
    put({4'ha, 1'b0, 3'(s)}, 1'b0);
    put({4'hb, 1'b0, 3'(s)}, 1'b1);
    rx_valid = 1'b0;
    rx_last  = 1'b0;
    rx_data  = ~rx_data; // released line shows no stale byte
    repeat (slow ? 3 : 1) @(posedge core_clk);
    #1;
  endtask : pkt

  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_last  = 1'b0;
    rx_data  = 8'h00;
    n_pkt    = 0;
    last_hdr = '0;
    req_hdr  = '0;
    prev_tag = 16'h5a5a; // differs from the first tag
    forever begin
      @(posedge core_clk);
      #1 tx_ready = 1'b1;
      k = 0;
      while (k < 8) begin
        @(posedge core_clk);
        if (tx_valid === 1'b1 && tx_ready) begin
          hdr[k] = tx_data;
          k++;
        end
        #1 tx_ready = (k < 8) && (!slow || !tx_ready);
      end
      n_pkt++;
      last_hdr = {hdr[0], hdr[1], hdr[2], hdr[3], hdr[4], hdr[5], hdr[6], hdr[7]};
      if (hdr[0][7:6] == tpe_pkg::FN_REQ) begin
        req_hdr  = last_hdr;
        fresh    = ({hdr[2], hdr[3]} != prev_tag);
        prev_tag = {hdr[2], hdr[3]};
        if (junk && fresh) begin
          pkt(tpe_pkg::FN_NONE, 0, 1'b0, 1'b0);
          pkt(tpe_pkg::FN_RESP, 8, 1'b0, 1'b0);
        end
        for (int s = 0; s < 8 && !mute; s++) begin
          if (hdr[1][s] && !(fresh && drop_map[s]) && s <= eom_seq) begin
            pkt(tpe_pkg::FN_RESP, s, s == eom_seq, fresh && sts_once);
            if (fresh && sts_once) break;
          end
        end
      end
    end
  end
endmodule : tpe_peer

// >>> rtl/tpe_buf_if.sv
`timescale 1ns/100ps
interface tpe_buf_if;
  logic               in_valid;
  logic               in_ready;
  tpe_pkg::tpe_word_s in_word;
  logic               out_valid;
  logic               out_ready;
  tpe_pkg::tpe_word_s out_word;

  modport fill  (output in_valid, in_word, out_ready, input in_ready, out_valid, out_word);
  modport store (input in_valid, in_word, out_ready, output in_ready, out_valid, out_word);
endinterface : tpe_buf_if

// >>> rtl/tpe_pkg.sv
package tpe_pkg;

  // packet function codes in the top two bits of the command_control_byte
  localparam logic [1:0] FN_NONE = 2'h0;
  localparam logic [1:0] FN_REQ  = 2'h1;
  localparam logic [1:0] FN_RESP = 2'h2;
  localparam logic [1:0] FN_REL  = 2'h3;

  // command_control_byte flag positions
  localparam int ONCE_BIT = 5;
  localparam int EOM_BIT  = 4;
  localparam int STS_BIT  = 3;

  // header layout: byte index of each field, first byte on the wire is 0
  localparam logic [2:0] IDX_CCB    = 3'h0;
  localparam logic [2:0] IDX_MAP    = 3'h1;
  localparam logic [2:0] IDX_TAG_HI = 3'h2;
  localparam logic [2:0] IDX_TAG_LO = 3'h3;
  localparam logic [2:0] IDX_USR0   = 3'h4;
  localparam logic [2:0] IDX_USR1   = 3'h5;
  localparam logic [2:0] IDX_USR2   = 3'h6;
  localparam logic [2:0] IDX_LAST   = 3'h7;

  localparam logic [9:0] MAX_PAYLOAD = 10'h242;
  localparam logic [7:0] MAX_SEQ     = 8'h07;

  // reset values
  localparam logic [15:0] TAG_RST = 16'hffff;

  // timeout prescaler: one tick per millisecond
  localparam int CLK_PERIOD_NS = 32'h0000_000a;
  localparam int TICK_NS       = 32'h000f_4240;
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRESC_W       = 17;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b10
  } tpe_tx_e;

  typedef enum logic [0:0] {
    RX_HDR = 1'b0,
    RX_PAY = 1'b1
  } tpe_rx_e;

  typedef struct packed {
    logic       bad;
    logic       last;
    logic [2:0] seq;
    logic [7:0] data;
  } tpe_word_s;

endpackage : tpe_pkg

// >>> rtl/tpe_requester.sv
`timescale 1ns/100ps
// Behaviour
// - header is eight bytes; payloads over 578 bytes are rejected.
// - top two bits of byte 0: 01 request, 10 response, 11 release.
// - end_of_message_flag appears only in the last response packet.
// - exactly-once requests carry once_only_flag set.
// - status_request_flag in a response forces an immediate resend.
// - the three spare command bits are sent as zero.
// - the bitmap/sequence byte follows the command byte in every packet.
// - a response's sequence byte is 0 to 7.
// - request bitmap bit i asks for response packet i.
// - tag sits in header bytes two and three.
// - on status_request_flag send the current bitmap at once.
// - a response message has at most eight packets.
module tpe_requester #(
  parameter int TICK_CYCLES_P = tpe_pkg::TICK_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        req_start,
  input  wire logic        req_once_only,
  input  wire logic [7:0]  req_bitmap,
  input  wire logic [31:0] req_user,
  input  wire logic [15:0] req_timeout_ticks,
  input  wire logic [3:0]  req_max_retries,
  output wire logic        req_busy,
  output wire logic        req_done,
  output wire logic        req_ok,
  output wire logic [3:0]  req_rcv_count,
  output wire logic [15:0] req_tag,
  output wire logic [7:0]  resp_data,
  output wire logic [2:0]  resp_seq,
  output wire logic        resp_last,
  output wire logic        resp_bad,
  output wire logic        resp_valid,
  input  wire logic        resp_ready,
  output wire logic [31:0] resp_user,
  output wire logic        resp_user_valid,
  output wire logic [7:0]  tx_data,
  output wire logic        tx_valid,
  output wire logic        tx_last,
  input  wire logic        tx_ready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        rx_last,
  output wire logic        rx_ready
);

  localparam logic [tpe_pkg::PRESC_W-1:0] TICK_LAST = tpe_pkg::PRESC_W'(TICK_CYCLES_P - 1);

  typedef struct packed {
    tpe_pkg::tpe_tx_e st;
    logic [2:0]       bcnt;
    logic             rel;
    logic [7:0]       tx_data;
    logic             tx_valid;
    logic             tx_last;
    logic [15:0]      tag;
    logic [7:0]       bitmap;
    logic             once;
    logic [31:0]      user;
    logic [15:0]      timeout;
    logic [3:0]       max_retry;
    logic [3:0]       retries;
    logic [15:0]      timer;
    logic [tpe_pkg::PRESC_W-1:0] presc;
    logic             sts_pend;
    logic             busy;
    logic             done;
    logic             ok;
    logic [3:0]       rcv;
    tpe_pkg::tpe_rx_e rx_st;
    logic [2:0]       hcnt;
    logic [7:0][7:0]  hdr;
    logic [9:0]       pcnt;
    logic             pass;
    logic             over;
    logic [31:0]      resp_user;
    logic             resp_user_valid;
  } tpe_req_s;

  tpe_req_s  s_r;
  tpe_req_s  s_nxt;
  tpe_buf_if bus ();

  logic [7:0][7:0] hd;
  logic [1:0]      fn;
  logic            end_of_message_flag;
  logic            sts;
  logic [7:0]      seqb;
  logic [15:0]     rtag;
  logic            taken;
  logic            active;
  logic            match;
  logic            pkt_end;
  logic            over_now;
  logic            good_end;
  logic            launch;
  logic            launch_rel;
  logic [7:0]      clr_mask;

  // builds one header byte of an outgoing request or release
  function automatic logic [7:0] hdr_byte(input logic [2:0] idx, input logic rel,
                                          input logic once, input logic [7:0] bm,
                                          input logic [15:0] tag, input logic [31:0] user);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      tpe_pkg::IDX_CCB: begin
        b = 8'h00; // spare bits stay zero
        b[7:6] = rel ? tpe_pkg::FN_REL : tpe_pkg::FN_REQ;
        b[tpe_pkg::ONCE_BIT] = once & ~rel;
      end
      tpe_pkg::IDX_MAP:    b = rel ? 8'h00 : bm;
      tpe_pkg::IDX_TAG_HI: b = tag[15:8];
      tpe_pkg::IDX_TAG_LO: b = tag[7:0];
      tpe_pkg::IDX_USR0:   b = user[31:24];
      tpe_pkg::IDX_USR1:   b = user[23:16];
      tpe_pkg::IDX_USR2:   b = user[15:8];
      tpe_pkg::IDX_LAST:   b = user[7:0];
      default:             b = 8'h00;
    endcase
    return b;
  endfunction : hdr_byte

  // bits to drop when a response is accepted
  for (genvar i = 0; i < 8; i++) begin : g_clr
    assign clr_mask[i] = (seqb[2:0] == 3'(i)) | (end_of_message_flag & (3'(i) > seqb[2:0]));
  end

  always_comb begin
    hd = s_r.hdr;
    if (s_r.rx_st == tpe_pkg::RX_HDR) begin
      hd[s_r.hcnt] = rx_data;
    end
    fn       = hd[tpe_pkg::IDX_CCB][7:6];
    end_of_message_flag      = hd[tpe_pkg::IDX_CCB][tpe_pkg::EOM_BIT];
    sts      = hd[tpe_pkg::IDX_CCB][tpe_pkg::STS_BIT];
    seqb     = hd[tpe_pkg::IDX_MAP];
    rtag     = {hd[tpe_pkg::IDX_TAG_HI], hd[tpe_pkg::IDX_TAG_LO]};
    taken    = rx_valid & bus.in_ready;
    active   = ((s_r.st == tpe_pkg::ST_SEND) | (s_r.st == tpe_pkg::ST_WAIT)) & ~s_r.rel;
    // function 00 and release never match
    match    = (fn == tpe_pkg::FN_RESP) & (rtag == s_r.tag) & active &
               (seqb <= tpe_pkg::MAX_SEQ) & s_r.bitmap[seqb[2:0]];
    pkt_end  = taken & rx_last & ((s_r.rx_st == tpe_pkg::RX_PAY) |
                                  (s_r.hcnt == tpe_pkg::IDX_LAST));
    over_now = s_r.over | ((s_r.rx_st == tpe_pkg::RX_PAY) &
                           (s_r.pcnt == tpe_pkg::MAX_PAYLOAD));
    good_end = pkt_end & ~over_now & ((s_r.rx_st == tpe_pkg::RX_HDR) ? match : s_r.pass);
  end

  // payload of a matching response goes to the client tagged with its slot
  assign bus.in_valid      = taken & (s_r.rx_st == tpe_pkg::RX_PAY) & s_r.pass;
  assign bus.in_word.data  = rx_data;
  assign bus.in_word.seq   = s_r.hdr[tpe_pkg::IDX_MAP][2:0];
  assign bus.in_word.last  = rx_last;
  assign bus.in_word.bad   = over_now;
  assign bus.out_ready     = resp_ready;

  always_comb begin
    s_nxt                 = s_r;
    s_nxt.done            = 1'b0;
    s_nxt.resp_user_valid = 1'b0;
    launch                = 1'b0;
    launch_rel            = 1'b0;

    case (s_r.st)
      tpe_pkg::ST_IDLE: begin
        if (req_start) begin
          s_nxt.tag       = s_r.tag + 16'h0001;
          s_nxt.bitmap    = req_bitmap;
          s_nxt.once      = req_once_only;
          s_nxt.user      = req_user;
          s_nxt.timeout   = req_timeout_ticks;
          s_nxt.max_retry = req_max_retries;
          s_nxt.retries   = 4'h0;
          s_nxt.rcv       = 4'h0;
          s_nxt.sts_pend  = 1'b0;
          s_nxt.busy      = 1'b1;
          launch          = 1'b1;
        end
      end
      tpe_pkg::ST_SEND: begin
        if (s_r.tx_valid & tx_ready) begin
          if (s_r.bcnt == tpe_pkg::IDX_LAST) begin
            s_nxt.tx_valid = 1'b0;
            s_nxt.tx_last  = 1'b0;
            s_nxt.st       = s_r.rel ? tpe_pkg::ST_IDLE : tpe_pkg::ST_WAIT;
            s_nxt.busy     = ~s_r.rel;
          end else begin
            s_nxt.bcnt    = s_r.bcnt + 3'h1;
            s_nxt.tx_data = hdr_byte(s_nxt.bcnt, s_r.rel, s_r.once, s_r.bitmap, s_r.tag,
                                     s_r.user);
            s_nxt.tx_last = (s_nxt.bcnt == tpe_pkg::IDX_LAST);
          end
        end
      end
      tpe_pkg::ST_WAIT: begin
        if (s_r.presc == TICK_LAST) begin
          s_nxt.presc = '0;
          s_nxt.timer = s_r.timer + {15'h0000, (s_r.timer != 16'hffff)};
        end else begin
          s_nxt.presc = s_r.presc + tpe_pkg::PRESC_W'(1);
        end
        if (s_r.bitmap == 8'h00) begin
          s_nxt.done = 1'b1;
          s_nxt.ok   = 1'b1;
          // exactly-once responders hold the answer until released
          if (s_r.once) begin
            launch     = 1'b1;
            launch_rel = 1'b1;
          end else begin
            s_nxt.st   = tpe_pkg::ST_IDLE;
            s_nxt.busy = 1'b0;
          end
        end else if (s_r.sts_pend) begin
          s_nxt.sts_pend = 1'b0; // retries untouched, timer restarted
          launch         = 1'b1;
        end else if (s_r.timer >= s_r.timeout) begin
          if (s_r.retries == s_r.max_retry) begin
            s_nxt.done = 1'b1;
            s_nxt.ok   = 1'b0;
            s_nxt.st   = tpe_pkg::ST_IDLE;
            s_nxt.busy = 1'b0;
          end else begin
            s_nxt.retries = s_r.retries + 4'h1;
            launch        = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.st = tpe_pkg::ST_IDLE;
      end
    endcase

    if (launch) begin
      s_nxt.st       = tpe_pkg::ST_SEND;
      s_nxt.rel      = launch_rel;
      s_nxt.bcnt     = tpe_pkg::IDX_CCB;
      s_nxt.tx_valid = 1'b1;
      s_nxt.tx_last  = 1'b0;
      s_nxt.tx_data  = hdr_byte(tpe_pkg::IDX_CCB, launch_rel, s_nxt.once, s_nxt.bitmap,
                                s_nxt.tag, s_nxt.user);
      s_nxt.timer    = 16'h0000;
      s_nxt.presc    = '0;
    end

    // receive side runs beside the sender; header first, then payload
    if (taken) begin
      if (s_r.rx_st == tpe_pkg::RX_HDR) begin
        s_nxt.hdr = hd;
        if (rx_last) begin
          s_nxt.hcnt = 3'h0;
        end else if (s_r.hcnt == tpe_pkg::IDX_LAST) begin
          s_nxt.rx_st = tpe_pkg::RX_PAY;
          s_nxt.pass  = match;
          s_nxt.pcnt  = 10'h000;
          s_nxt.over  = 1'b0;
          s_nxt.hcnt  = 3'h0;
        end else begin
          s_nxt.hcnt = s_r.hcnt + 3'h1;
        end
      end else begin
        s_nxt.over = over_now;
        if (!over_now) begin
          s_nxt.pcnt = s_r.pcnt + 10'h001;
        end
        if (rx_last) begin
          s_nxt.rx_st = tpe_pkg::RX_HDR;
          s_nxt.hcnt  = 3'h0;
        end
      end
    end

    // set wins over the sender's clear of the status flag
    if (good_end) begin
      s_nxt.bitmap          = s_r.bitmap & ~clr_mask;
      s_nxt.rcv             = s_r.rcv + 4'h1;
      s_nxt.resp_user       = {hd[tpe_pkg::IDX_USR0], hd[tpe_pkg::IDX_USR1],
                               hd[tpe_pkg::IDX_USR2], hd[tpe_pkg::IDX_LAST]};
      s_nxt.resp_user_valid = 1'b1;
      if (sts) begin
        s_nxt.sts_pend = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r     <= '0;
      s_r.tag <= tpe_pkg::TAG_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  tpe_skid u_skid (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .bus      (bus)
  );

  assign req_busy        = s_r.busy;
  assign req_done        = s_r.done;
  assign req_ok          = s_r.ok;
  assign req_rcv_count   = s_r.rcv;
  assign req_tag         = s_r.tag;
  assign resp_data       = bus.out_word.data;
  assign resp_seq        = bus.out_word.seq;
  assign resp_last       = bus.out_word.last;
  assign resp_bad        = bus.out_word.bad;
  assign resp_valid      = bus.out_valid;
  assign resp_user       = s_r.resp_user;
  assign resp_user_valid = s_r.resp_user_valid;
  assign tx_data         = s_r.tx_data;
  assign tx_valid        = s_r.tx_valid;
  assign tx_last         = s_r.tx_last;
  assign rx_ready        = bus.in_ready;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_ccb_out;
    s_r.tx_valid && (s_r.bcnt == tpe_pkg::IDX_CCB);
  endsequence

  sequence s_status_due;
    (s_r.st == tpe_pkg::ST_WAIT) && s_r.sts_pend && (s_r.bitmap != 8'h00);
  endsequence

  chk_tag_increment: assert property (
    (s_r.st == tpe_pkg::ST_IDLE) && req_start |=> s_r.tag == $past(s_r.tag) + 16'h0001)
    else $error("tag did not step by one");
  chk_function_code: assert property (
    s_ccb_out |-> (s_r.tx_data[7:6] == (s_r.rel ? tpe_pkg::FN_REL : tpe_pkg::FN_REQ)))
    else $error("wrong function code sent");
  chk_spare_bits: assert property (
    s_ccb_out |-> (s_r.tx_data[4:0] == 5'h00))
    else $error("spare command bits not zero");
  chk_once_flag: assert property (
    (s_ccb_out and !s_r.rel) |-> (s_r.tx_data[tpe_pkg::ONCE_BIT] == s_r.once))
    else $error("once_only_flag mismatch");
  chk_header_len: assert property (
    (s_ccb_out and tx_ready) |=> !s_r.tx_last [*6] ##1 (s_r.tx_last || !tx_ready))
    else $error("header end not on eighth byte");
  chk_tag_bytes: assert property (
    s_r.tx_valid && (s_r.bcnt == tpe_pkg::IDX_TAG_HI) |-> s_r.tx_data == s_r.tag[15:8])
    else $error("tag high byte misplaced");
  chk_seq_clear: assert property (
    good_end |=> !s_r.bitmap[$past(seqb[2:0])] && s_r.rcv == $past(s_r.rcv) + 4'h1)
    else $error("accepted response did not clear its bit");
  chk_eom_clear: assert property (
    good_end && end_of_message_flag |=> (s_r.bitmap >> $past(seqb[2:0])) == 8'h00)
    else $error("bits above end of message left set");
  chk_status_resend: assert property (
    s_status_due |=> (s_r.st == tpe_pkg::ST_SEND) && s_r.timer == 16'h0000 &&
                     $stable(s_r.retries))
    else $error("status resend wrong");
  chk_timeout_resend: assert property (
    (s_r.st == tpe_pkg::ST_WAIT) && (s_r.bitmap != 8'h00) && !s_r.sts_pend &&
    (s_r.timer >= s_r.timeout) && (s_r.retries != s_r.max_retry)
    |=> (s_r.st == tpe_pkg::ST_SEND) && $stable(s_r.tag) &&
        s_r.retries == $past(s_r.retries) + 4'h1)
    else $error("timeout resend wrong");
  chk_retry_stop: assert property (
    (s_r.st == tpe_pkg::ST_WAIT) && (s_r.bitmap != 8'h00) && !s_r.sts_pend &&
    (s_r.timer >= s_r.timeout) && (s_r.retries == s_r.max_retry)
    |=> req_done && !req_ok && (s_r.st == tpe_pkg::ST_IDLE))
    else $error("retry limit not reported");
  chk_null_drop: assert property (
    pkt_end && (fn == tpe_pkg::FN_NONE) |=> $stable(s_r.bitmap) && !s_r.resp_user_valid)
    else $error("function 00 packet changed state");

endmodule : tpe_requester

// >>> rtl/tpe_skid.sv
`timescale 1ns/100ps
module tpe_skid (
  input wire logic core_clk,
  input wire logic arst_n,
  tpe_buf_if.store bus
);

  typedef struct packed {
    logic [1:0]         cnt;
    logic               rdy;
    logic               vld;
    tpe_pkg::tpe_word_s e0;
    tpe_pkg::tpe_word_s e1;
  } tpe_skid_s;

  tpe_skid_s s_r;
  tpe_skid_s s_nxt;

  logic       push;
  logic       pop;
  logic [1:0] after_pop;

  // ready is registered; two entries let it lag one cycle without loss
  always_comb begin
    s_nxt     = s_r;
    push      = bus.in_valid & s_r.rdy;
    pop       = s_r.vld & bus.out_ready;
    after_pop = s_r.cnt - {1'b0, pop};
    if (pop) begin
      s_nxt.e0 = s_r.e1;
    end
    if (push) begin
      if (after_pop == 2'h0) begin
        s_nxt.e0 = bus.in_word;
      end else begin
        s_nxt.e1 = bus.in_word;
      end
    end
    s_nxt.cnt = after_pop + {1'b0, push};
    s_nxt.rdy = (s_nxt.cnt != 2'h2);
    s_nxt.vld = (s_nxt.cnt != 2'h0);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.in_ready  = s_r.rdy;
  assign bus.out_valid = s_r.vld;
  assign bus.out_word  = s_r.e0;

endmodule : tpe_skid
